// File: rtl/bpe_pkg.sv
// How it works
// - Secondary detected-parity bit sets on secondary-bus errors regardless of both enables.
// - That bit sets only for downstream reads and upstream posted or delayed writes.
// - Primary master parity bit needs primary mastership, primary enable, and an error there.
// - Primary master parity bit sets only for upstream transactions erring on primary.
// - Secondary master parity bit needs secondary mastership and an error there.
// - Secondary master parity bit also needs the secondary enable; otherwise unchanged.
// - Secondary master parity bit sets only for downstream transactions erring on secondary.
// - Primary parity output only as write target or read initiator on primary.
// - Primary parity output only while the primary enable is set.
// - Primary output fires on primary errors or secondary input during downstream delayed write.
// - Primary detected bit sets for upstream reads and downstream writes erring on primary.
// - Downstream delayed write erring only on secondary needs both enables for primary output.
// - Parity output is driven two clocks after the data transfer completes.
package bpe_pkg;

  localparam logic [3:0] BPE_OFS_CTRL   = 4'h0;
  localparam logic [3:0] BPE_OFS_STATUS = 4'h4;
  localparam logic [3:0] BPE_OFS_MASK   = 4'h8;
  localparam logic [3:0] BPE_OFS_LOG    = 4'hc;

  localparam int BPE_CTRL_PRI_EN = 0;
  localparam int BPE_CTRL_SEC_EN = 1;

  localparam int BPE_ST_PRI_DET  = 0;
  localparam int BPE_ST_PRI_MST  = 1;
  localparam int BPE_ST_SEC_DET  = 2;
  localparam int BPE_ST_SEC_MST  = 3;
  localparam int BPE_ST_PERR_OUT = 4;
  localparam int BPE_ST_W        = 5;

  localparam logic [1:0]          BPE_CTRL_RST   = 2'h0;
  localparam logic [BPE_ST_W-1:0] BPE_STATUS_RST = 5'h00;
  localparam logic [BPE_ST_W-1:0] BPE_MASK_RST   = 5'h00;

  localparam int BPE_PERR_DELAY_NS  = 20;
  localparam int BPE_CLK_PERIOD_NS  = 10;
  localparam int BPE_PERR_DELAY_CYC = BPE_PERR_DELAY_NS / BPE_CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    BPE_XACT_READ    = 2'b00,
    BPE_XACT_POSTED  = 2'b01,
    BPE_XACT_DELAYED = 2'b10
  } bpe_xact_e;

  typedef struct packed
  {
    logic      valid;
    bpe_xact_e xact;
    logic      downstream;
    logic      on_secondary;
  } bpe_event_s;

  typedef struct packed
  {
    logic pri_det;
    logic pri_mst;
    logic sec_det;
    logic sec_mst;
    logic perr_req;
  } bpe_result_s;

endpackage

// File: rtl/bpe_decode.sv
`timescale 1ns/1ps
module bpe_decode
(
  input  wire bpe_pkg::bpe_event_s  ev,
  input  wire logic                 pri_en,
  input  wire logic                 sec_en,
  input  wire logic                 pri_perr_seen,
  input  wire logic                 sec_perr_seen,
  output bpe_pkg::bpe_result_s      res
);
  import bpe_pkg::*;

  logic is_read;
  logic is_posted;
  logic is_delayed;
  logic legal;
  logic up;
  logic err_pri;
  logic err_sec;

  always_comb
  begin
    is_read    = 1'b0;
    is_posted  = 1'b0;
    is_delayed = 1'b0;
    legal      = 1'b1;
    unique case (ev.xact)
      BPE_XACT_READ:    is_read    = 1'b1;
      BPE_XACT_POSTED:  is_posted  = 1'b1;
      BPE_XACT_DELAYED: is_delayed = 1'b1;
      default:          legal      = 1'b0;
    endcase
  end

  assign up      = ~ev.downstream;
  // Seeing the far agent's error signal counts as an error on that bus
  assign err_pri = ~ev.on_secondary | pri_perr_seen;
  assign err_sec = ev.on_secondary | sec_perr_seen;

  always_comb
  begin
    res          = '0;
    if (ev.valid && legal)
    begin
      res.sec_det = ev.on_secondary &&
                    ((is_read && ev.downstream) || (~is_read && up));
      res.pri_det = ~ev.on_secondary &&
                    ((is_read && up) || (~is_read && ev.downstream));
      res.pri_mst = up && pri_en && err_pri;
      res.sec_mst = ev.downstream && sec_en && err_sec;
      res.perr_req = pri_en &&
                     ((~ev.on_secondary &&
                       ((is_read && up) || (~is_read && ev.downstream))) ||
                      (is_delayed && ev.downstream && err_sec && sec_en));
    end
  end

endmodule // bpe_decode

// File: rtl/bpe_top.sv
`timescale 1ns/1ps
module bpe_top
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire bpe_pkg::bpe_event_s xfer_event,
  input  wire logic                primary_parity_err_n_i,
  output logic                     primary_parity_err_n_o,
  output logic                     primary_parity_err_n_oe,
  input  wire logic                secondary_parity_err_n_i,
  output logic                     irq
);
  import bpe_pkg::*;

  logic [1:0]                  ctrl_r;
  logic [BPE_ST_W-1:0]         status_r;
  logic [BPE_ST_W-1:0]         status_nxt;
  logic [BPE_ST_W-1:0]         mask_r;
  logic [4:0]                  log_r;
  logic                        ack_r;
  logic [31:0]                 rdata_r;
  logic [BPE_PERR_DELAY_CYC-1:0] perr_pipe_r;
  logic                        wr_take;
  logic                        rd_take;
  logic [BPE_ST_W-1:0]         set_bits;
  logic [BPE_ST_W-1:0]         clr_bits;
  bpe_result_s                 res;

  bpe_decode u_decode
  (
    .ev            (xfer_event),
    .pri_en        (ctrl_r[BPE_CTRL_PRI_EN]),
    .sec_en        (ctrl_r[BPE_CTRL_SEC_EN]),
    // Own drive on the shared line is not a report from the far agent
    .pri_perr_seen (~primary_parity_err_n_i & ~primary_parity_err_n_oe),
    .sec_perr_seen (~secondary_parity_err_n_i),
    .res           (res)
  );

  // One wait state; writes taken on the edge where waitrequest is low, reads sampled on the wait-state edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_take         = avs_write & ack_r;
  assign rd_take         = avs_read & ~ack_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (rd_take)
    begin
      unique case (avs_address)
        BPE_OFS_CTRL:   rdata_r <= {30'h0, ctrl_r};
        BPE_OFS_STATUS: rdata_r <= {27'h0, status_r};
        BPE_OFS_MASK:   rdata_r <= {27'h0, mask_r};
        BPE_OFS_LOG:    rdata_r <= {27'h0, log_r};
        default:        rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= BPE_CTRL_RST;
    else if (wr_take && avs_address == BPE_OFS_CTRL && avs_byteenable[0])
      ctrl_r <= avs_writedata[1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= BPE_MASK_RST;
    else if (wr_take && avs_address == BPE_OFS_MASK && avs_byteenable[0])
      mask_r <= avs_writedata[BPE_ST_W-1:0];
  end

  assign set_bits = {res.perr_req, res.sec_mst, res.sec_det, res.pri_mst, res.pri_det};
  assign clr_bits = (wr_take && avs_address == BPE_OFS_STATUS && avs_byteenable[0]) ?
                    avs_writedata[BPE_ST_W-1:0] : '0;
  // A new event beats a clear in the same cycle
  assign status_nxt = (status_r & ~clr_bits) | set_bits;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= BPE_STATUS_RST;
    else
      status_r <= status_nxt;
  end

  // Last event that set anything, for software post-mortem
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      log_r <= 5'h00;
    else if (|set_bits)
      log_r <= {1'b1, xfer_event.xact, xfer_event.downstream, xfer_event.on_secondary};
  end

  // Delay line so the pin drops after the data phase, not during it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      perr_pipe_r <= '0;
    else
      perr_pipe_r <= {perr_pipe_r[BPE_PERR_DELAY_CYC-2:0], res.perr_req};
  end

  // Only ever drives low; pull-up restores the level when released
  assign primary_parity_err_n_o  = 1'b0;
  assign primary_parity_err_n_oe = perr_pipe_r[BPE_PERR_DELAY_CYC-1];

  assign irq = |(status_r & mask_r);

endmodule // bpe_top

// File: verification/bpe_checker.sv
`timescale 1ns/1ps
module bpe_checker
  import bpe_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  input wire bpe_pkg::bpe_event_s xfer_event,
  input wire logic                primary_parity_err_n_o,
  input wire logic                primary_parity_err_n_oe,
  input wire logic                irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic ev = xfer_event.valid;
  AST_OE_TWO_AFTER: assert property (primary_parity_err_n_oe |-> $past(ev, 2))
    else $error("output driven without an event two cycles back");
  AST_OE_LOW: assert property (primary_parity_err_n_oe |-> !primary_parity_err_n_o)
    else $error("output enabled but not driving low");
  AST_DN_READ: assert property (ev && xfer_event.xact == BPE_XACT_READ && xfer_event.downstream
    |-> ##2 !primary_parity_err_n_oe)
    else $error("output driven for a downstream read");
  AST_UP_WRITE: assert property (ev && xfer_event.xact != BPE_XACT_READ && !xfer_event.downstream
    |-> ##2 !primary_parity_err_n_oe)
    else $error("output driven for an upstream write");
  AST_POSTED_SEC: assert property (ev && xfer_event.xact == BPE_XACT_POSTED
    && xfer_event.on_secondary |-> ##2 !primary_parity_err_n_oe)
    else $error("output driven for posted write erring on secondary");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt dropped without a write");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(ev) || $past(avs_write))
    else $error("interrupt rose without an event or write");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  cover property (primary_parity_err_n_oe);
  cover property ($fell(irq));
  cover property (avs_read && !avs_waitrequest);
endmodule // bpe_checker
bind bpe_top bpe_checker u_chk (.*);

// File: verification/bpe_agents.sv
`timescale 1ns/1ps
module bpe_agents
(
  input  wire logic pri_err,
  input  wire logic sec_err,
  input  wire logic dut_o,
  input  wire logic dut_oe,
  output logic      pri_n,
  output logic      sec_n
);
  // Pulled-up lines: a released line reads high, never the last value
  assign pri_n = !(pri_err || (dut_oe && !dut_o));
  assign sec_n = !sec_err;
endmodule // bpe_agents

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import bpe_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  bpe_event_s  xfer_event = '0;
  logic        sec_err = 1'b0;
  logic        pri_err = 1'b0;
  logic        primary_parity_err_n_i, secondary_parity_err_n_i, irq;
  logic        primary_parity_err_n_o, primary_parity_err_n_oe;
  logic [31:0] q;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  bpe_top dut
  (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_writedata            (avs_writedata),
    .avs_byteenable           (4'hf),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .xfer_event               (xfer_event),
    .primary_parity_err_n_i   (primary_parity_err_n_i),
    .primary_parity_err_n_o   (primary_parity_err_n_o),
    .primary_parity_err_n_oe  (primary_parity_err_n_oe),
    .secondary_parity_err_n_i (secondary_parity_err_n_i),
    .irq                      (irq)
  );
  bpe_agents agents (.pri_err(pri_err), .sec_err(sec_err), .dut_o(primary_parity_err_n_o),
    .dut_oe(primary_parity_err_n_oe), .pri_n(primary_parity_err_n_i),
    .sec_n(secondary_parity_err_n_i));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  // Waitrequest is judged at the rising edge, before that edge's updates land
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic ev_case(input logic [1:0] c, input logic [1:0] x, input logic d, s, sp, pp);
    logic rd, wr, oe_x;
    logic [4:0] e;
    rd = (x == 2'h0);
    wr = (x == 2'h1) || (x == 2'h2);
    oe_x = c[0] && ((!s && ((rd && !d) || (wr && d))) ||
      ((s || sp) && c[1] && x == 2'h2 && d));
    e = {oe_x, (s || sp) && d && c[1] && (rd || wr), s && ((rd && d) || (wr && !d)),
      (!s || pp) && !d && c[0] && (rd || wr), !s && ((rd && !d) || (wr && d))};
    bus(1'b1, BPE_OFS_CTRL, {30'h0, c});
    bus(1'b1, BPE_OFS_STATUS, 32'h1f);
    @(posedge clk_sys);
    xfer_event <= {1'b1, x, d, s};
    sec_err <= sp;
    pri_err <= pp;
    @(posedge clk_sys);
    xfer_event <= '0;
    sec_err <= 1'b0;
    pri_err <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("oe", {31'h0, primary_parity_err_n_oe}, {31'h0, oe_x});
    @(negedge clk_sys);
    chk("oe_end", {31'h0, primary_parity_err_n_oe}, 32'h0);
    bus(1'b0, BPE_OFS_STATUS, 32'h0);
    chk("status", q, {27'h0, e});
  endtask
  task automatic t_reset;
    logic [19:0] offs;
    offs = {4'h1, BPE_OFS_LOG, BPE_OFS_MASK, BPE_OFS_STATUS, BPE_OFS_CTRL};
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, offs[i*4+:4], 32'h0);
      chk("reset_reg", q, 32'h0);
    end
  endtask
  task automatic t_table;
    for (int k = 0; k < 32; k++)
      ev_case(k[4] ? 2'h0 : 2'h3, k[3:2], k[1], k[0], 1'b0, 1'b0);
  endtask
  // Secondary input alone, and with the bridge's own secondary detection
  task automatic t_delayed_sec;
    for (int c = 0; c < 8; c++)
      ev_case(c[1:0], 2'h2, 1'b1, c[2], 1'b1, 1'b0);
  endtask
  // Far agent's primary report on upstream transfers erring on secondary
  task automatic t_pri_input;
    for (int c = 0; c < 4; c++)
      ev_case(c[1:0], c[1] ? 2'h1 : 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_sticky;
    ev_case(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, BPE_OFS_STATUS, 32'h0);
    bus(1'b1, BPE_OFS_MASK, 32'h1f);
    bus(1'b0, BPE_OFS_STATUS, 32'h0);
    chk("sticky", q, 32'h13);
    chk("irq_on", {31'h0, irq}, 32'h1);
    bus(1'b1, BPE_OFS_STATUS, 32'h1f);
    bus(1'b0, BPE_OFS_STATUS, 32'h0);
    chk("cleared", q, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_table;
    t_delayed_sec;
    t_pri_input;
    t_sticky;
    report_and_stop;
  end
endmodule // tb
